/* logic/wwls_defines.vh */
`ifndef WWLS_DEFINES_VH
`define WWLS_DEFINES_VH
// access word widths
`define WWLS_W_SHORT 2'h0
`define WWLS_W_NORMAL 2'h1
`define WWLS_W_EXT 2'h2
`define WWLS_W_LONG 2'h3
// bus and register geometry
`define WWLS_BUS_W 64
`define WWLS_REG_W 40
`define WWLS_EXT_LO 24
`define WWLS_ZFILL 8
`define WWLS_HALF 32
`define WWLS_IDX_W 4
// transfer state codes
`define WWLS_ST_IDLE 1'h0
`define WWLS_ST_DONE 1'h1
`endif

/* logic/wwls_lane_map.v */
`timescale 1ns/1ps
`include "wwls_defines.vh"
// one bus lane: packs register data onto a 64-bit bus and unpacks bus data to registers
module wwls_lane_map (
   width,
   st_explicit,
   st_neighbour,
   ld_bus,
   bus_out,
   ld_explicit,
   ld_neighbour
);
   input wire [1:0] width;
   input wire [39:0] st_explicit;
   input wire [39:0] st_neighbour;
   input wire [63:0] ld_bus;
   output reg [63:0] bus_out;
   output reg [39:0] ld_explicit;
   output reg [39:0] ld_neighbour;

   // combinational packing by word width
   always @* begin
      bus_out = {`WWLS_BUS_W{1'b0}};
      ld_explicit = {`WWLS_REG_W{1'b0}};
      ld_neighbour = {`WWLS_REG_W{1'b0}};
      case (width)
         `WWLS_W_EXT: begin
            // value on the upper 40 bits, lower 24 forced to zero [R1] [R2]
            bus_out = {st_explicit, {`WWLS_EXT_LO{1'b0}}};
            ld_explicit = ld_bus[`WWLS_BUS_W-1:`WWLS_EXT_LO];
         end
         `WWLS_W_LONG: begin
            // full 64-bit lane, each half to bits 39..8, low 8 bits dropped [R8] [R17]
            bus_out = {st_neighbour[`WWLS_REG_W-1:`WWLS_ZFILL],
                       st_explicit[`WWLS_REG_W-1:`WWLS_ZFILL]};
            ld_explicit = {ld_bus[`WWLS_HALF-1:0], {`WWLS_ZFILL{1'b0}}}; // [R10]
            ld_neighbour = {ld_bus[`WWLS_BUS_W-1:`WWLS_HALF], {`WWLS_ZFILL{1'b0}}}; // [R10]
         end
         default: begin
            // short and normal words: 32-bit low lane, low 8 register bits zero [R16]
            bus_out = {{`WWLS_HALF{1'b0}}, st_explicit[`WWLS_REG_W-1:`WWLS_ZFILL]};
            ld_explicit = {ld_bus[`WWLS_HALF-1:0], {`WWLS_ZFILL{1'b0}}};
         end
      endcase
   end
endmodule

/* logic/wwls_steer.v */
// Summary of operation
// R1 - extended value on bus upper 40 bits
// R2 - extended access zeroes bus low 24 bits
// R3 - single extended access same in both modes
// R4 - single-instruction dual access allows any widths
// R5 - paired dual extended: no complementary transfer
// R6 - paired dual: data bus primary, program secondary; code pins them for wide widths only
// R7 - paired dual wide needs wide other bus
// R8 - long word uses full 64-bit lane
// R9 - single long moves named plus neighbour
// R10 - single long load clears low 8 bits
// R11 - dual long moves four registers, clears
// R12 - neighbour conflict: only higher priority access runs
// R13 - software avoids neighbour-conflicting dual long pairs
// R14 - single-instruction dual extended honours named element
// R15 - dual access refuses direct addressing
// R16 - 32-bit access clears, truncates low 8 bits
// R17 - long halves map to register bits 39..8
// R18 - fixed pairing table gives neighbour register
`timescale 1ns/1ps
`include "wwls_defines.vh"
module wwls_steer #(
   parameter IDX_W = `WWLS_IDX_W
) (
   core_clk,
   nrst,
   req_valid,
   req_dual,
   req_paired_mode,
   req_store,
   req_direct,
   dm_width,
   pm_width,
   dm_reg_idx,
   pm_reg_idx,
   dm_secondary,
   pm_secondary,
   dm_has_priority,
   dm_st_explicit,
   dm_st_neighbour,
   pm_st_explicit,
   pm_st_neighbour,
   data_memory_bus_in,
   program_memory_bus_in,
   data_memory_bus_out,
   program_memory_bus_out,
   dm_bus_en,
   pm_bus_en,
   dm_wr_en,
   dm_wr_nb_en,
   dm_wr_idx,
   dm_wr_nb_idx,
   dm_wr_secondary,
   dm_wr_data,
   dm_wr_nb_data,
   pm_wr_en,
   pm_wr_nb_en,
   pm_wr_idx,
   pm_wr_nb_idx,
   pm_wr_secondary,
   pm_wr_data,
   pm_wr_nb_data,
   req_refused,
   req_done
);
   input wire core_clk;
   input wire nrst;
   input wire req_valid; // one-cycle access request
   input wire req_dual; // both buses used
   input wire req_paired_mode; // paired-element mode active
   input wire req_store; // register to memory when high
   input wire req_direct; // immediate-address form
   input wire [1:0] dm_width;
   input wire [1:0] pm_width;
   input wire [IDX_W-1:0] dm_reg_idx;
   input wire [IDX_W-1:0] pm_reg_idx;
   input wire dm_secondary; // named register lies in secondary element
   input wire pm_secondary;
   input wire dm_has_priority; // register-file priority for conflicts
   input wire [39:0] dm_st_explicit;
   input wire [39:0] dm_st_neighbour;
   input wire [39:0] pm_st_explicit;
   input wire [39:0] pm_st_neighbour;
   input wire [63:0] data_memory_bus_in;
   input wire [63:0] program_memory_bus_in;
   output reg [63:0] data_memory_bus_out;
   output reg [63:0] program_memory_bus_out;
   output reg dm_bus_en;
   output reg pm_bus_en;
   output reg dm_wr_en;
   output reg dm_wr_nb_en;
   output reg [IDX_W-1:0] dm_wr_idx;
   output reg [IDX_W-1:0] dm_wr_nb_idx;
   output reg dm_wr_secondary;
   output reg [39:0] dm_wr_data;
   output reg [39:0] dm_wr_nb_data;
   output reg pm_wr_en;
   output reg pm_wr_nb_en;
   output reg [IDX_W-1:0] pm_wr_idx;
   output reg [IDX_W-1:0] pm_wr_nb_idx;
   output reg pm_wr_secondary;
   output reg [39:0] pm_wr_data;
   output reg [39:0] pm_wr_nb_data;
   output reg req_refused; // one-cycle pulse: request dropped whole
   output reg req_done; // one-cycle pulse: request carried out

   // the neighbour of an even register is the next odd one and back again;
   // the same function feeds the collision check and the write ports,
   // so the pairing cannot drift between them
   // fixed neighbour pairing: even and odd registers pair up [R18]
   function [IDX_W-1:0] nb_of;
      input [IDX_W-1:0] idx;
      begin
         nb_of = idx ^ {{(IDX_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // true for the extended and long widths
   function is_wide;
      input [1:0] w;
      begin
         is_wide = (w == `WWLS_W_EXT) || (w == `WWLS_W_LONG);
      end
   endfunction

   wire [63:0] dm_bus_d; // packed data-bus value
   wire [63:0] pm_bus_d; // packed program-bus value
   wire [39:0] dm_ld_x; // unpacked data-bus explicit value
   wire [39:0] dm_ld_n; // unpacked data-bus neighbour value
   wire [39:0] pm_ld_x;
   wire [39:0] pm_ld_n;
   reg refuse_d; // request is illegal as a whole
   reg dm_go_d; // data-bus access proceeds
   reg pm_go_d; // program-bus access proceeds
   reg dm_sec_d; // element of data-bus target
   reg pm_sec_d; // element of program-bus target
   reg conflict_d; // neighbour collision between dual long accesses
   // outcome state: set by an executed request, held while requests continue, cleared by a cycle with no request;
   // it is kept for observation and does not gate any output
   reg state_q; // last request outcome state

   // both lanes share one packing module; each sees only its own width,
   // its own store operands and its own incoming bus word
   // the packer is pure logic: the output stage below registers its results
   // limitation: short words use the normal-word lane mapping here
   // data-bus lane packer [R1] [R2] [R8]
   wwls_lane_map u_dm_lane (
      .width(dm_width),
      .st_explicit(dm_st_explicit),
      .st_neighbour(dm_st_neighbour),
      .ld_bus(data_memory_bus_in),
      .bus_out(dm_bus_d),
      .ld_explicit(dm_ld_x),
      .ld_neighbour(dm_ld_n)
   );

   // program-bus lane packer
   wwls_lane_map u_pm_lane (
      .width(pm_width),
      .st_explicit(pm_st_explicit),
      .st_neighbour(pm_st_neighbour),
      .ld_bus(program_memory_bus_in),
      .bus_out(pm_bus_d),
      .ld_explicit(pm_ld_x),
      .ld_neighbour(pm_ld_n)
   );

   // decode overview:
   // - a request is taken on the rising edge that sees req_valid high
   // - single accesses always steer through the data-bus side ports
   // - dual accesses without a collision use both lanes and both register-file write ports
   // - direct addressing on a dual access refuses the whole request
   // - paired mode refuses a wide width on one bus with a narrow one
   // - refusal leaves every strobe, enable and store lane low
   // - paired wide dual accesses pin data bus to primary, program to secondary
   // - single-instruction dual accesses keep the element each side names
   // - a long word on one side claims the named register and its neighbour
   // - if the other side names that neighbour, the two accesses collide
   // - the collision check also needs both targets in one element
   // - on a collision only the side with register-file priority proceeds
   // - the losing side raises no bus enable and no write strobe
   // - paired wide accesses sit in different elements and never collide
   // request decode: legality, element choice and conflict resolution
   always @* begin
      refuse_d = 1'b0;
      conflict_d = 1'b0;
      dm_go_d = 1'b0;
      pm_go_d = 1'b0;
      dm_sec_d = dm_secondary; // single access uses the named element [R3] [R14]
      pm_sec_d = pm_secondary; // [R14]
      if (req_valid) begin
         if (req_dual) begin
            if (req_direct) begin
               refuse_d = 1'b1; // dual access needs generator addresses [R15]
            end else if (req_paired_mode &&
                         (is_wide(dm_width) != is_wide(pm_width))) begin
               refuse_d = 1'b1; // wide pairs only with wide [R7]
            end else begin
               // any width mix accepted in single-instruction mode [R4]
               dm_go_d = 1'b1;
               pm_go_d = 1'b1;
               if (req_paired_mode && is_wide(dm_width)) begin
                  dm_sec_d = 1'b0; // data bus to primary element [R6]
                  pm_sec_d = 1'b1; // program bus to secondary element [R6]
               end
               // explicit target equal to other's neighbour [R12] [R13]
               if ((dm_width == `WWLS_W_LONG &&
                    nb_of(dm_reg_idx) == pm_reg_idx && dm_sec_d == pm_sec_d) ||
                   (pm_width == `WWLS_W_LONG &&
                    nb_of(pm_reg_idx) == dm_reg_idx && dm_sec_d == pm_sec_d)) begin
                  conflict_d = 1'b1;
                  dm_go_d = dm_has_priority; // [R12]
                  pm_go_d = ~dm_has_priority; // [R12]
               end
            end
         end else begin
            // single access on the data bus, same in both modes [R3] [R9]
            dm_go_d = 1'b1;
         end
      end
   end

   // output stage timing:
   // - every output is a flip-flop, updated on each rising clock edge
   // - results appear right after the request edge and stand one cycle
   // - with no request the strobes drop and the store lanes return to zero
   // - back-to-back requests are accepted on consecutive edges
   // - store data is driven only while a proceeding store is in flight
   // - load data is captured every cycle; the write strobes qualify it
   // - neighbour strobes rise only for long-word loads
   // - write indices follow the request even when no strobe is raised
   // - req_refused and req_done never rise together
   // - the reset branch loads constants only
   // hazard: load data is sampled from the bus on the request edge, so the
   // memory side must present read data in the same cycle as req_valid
   // registered outputs of the steering stage
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         data_memory_bus_out <= {`WWLS_BUS_W{1'b0}};
         program_memory_bus_out <= {`WWLS_BUS_W{1'b0}};
         dm_bus_en <= 1'b0;
         pm_bus_en <= 1'b0;
         dm_wr_en <= 1'b0;
         dm_wr_nb_en <= 1'b0;
         dm_wr_idx <= {IDX_W{1'b0}};
         dm_wr_nb_idx <= {IDX_W{1'b0}};
         dm_wr_secondary <= 1'b0;
         dm_wr_data <= {`WWLS_REG_W{1'b0}};
         dm_wr_nb_data <= {`WWLS_REG_W{1'b0}};
         pm_wr_en <= 1'b0;
         pm_wr_nb_en <= 1'b0;
         pm_wr_idx <= {IDX_W{1'b0}};
         pm_wr_nb_idx <= {IDX_W{1'b0}};
         pm_wr_secondary <= 1'b0;
         pm_wr_data <= {`WWLS_REG_W{1'b0}};
         pm_wr_nb_data <= {`WWLS_REG_W{1'b0}};
         req_refused <= 1'b0;
         req_done <= 1'b0;
         state_q <= `WWLS_ST_IDLE;
      end else begin
         // stores drive the bus, idle or load leave it zero
         data_memory_bus_out <= (dm_go_d && req_store) ? dm_bus_d : {`WWLS_BUS_W{1'b0}};
         program_memory_bus_out <= (pm_go_d && req_store) ? pm_bus_d : {`WWLS_BUS_W{1'b0}};
         dm_bus_en <= dm_go_d;
         pm_bus_en <= pm_go_d;
         // loads: explicit register, neighbour only for long words [R9] [R11]
         dm_wr_en <= dm_go_d && !req_store;
         dm_wr_nb_en <= dm_go_d && !req_store && (dm_width == `WWLS_W_LONG); // [R11]
         pm_wr_en <= pm_go_d && !req_store;
         pm_wr_nb_en <= pm_go_d && !req_store && (pm_width == `WWLS_W_LONG); // [R11]
         // no complementary write for paired dual extended access [R5]
         dm_wr_idx <= dm_reg_idx;
         dm_wr_nb_idx <= nb_of(dm_reg_idx); // [R18]
         dm_wr_secondary <= dm_sec_d;
         dm_wr_data <= dm_ld_x;
         dm_wr_nb_data <= dm_ld_n;
         pm_wr_idx <= pm_reg_idx;
         pm_wr_nb_idx <= nb_of(pm_reg_idx); // [R18]
         pm_wr_secondary <= pm_sec_d;
         pm_wr_data <= pm_ld_x;
         pm_wr_nb_data <= pm_ld_n;
         req_refused <= refuse_d;
         req_done <= req_valid && !refuse_d;
         // outcome state: done after any executed request
         case (state_q)
            `WWLS_ST_IDLE: begin
               if (req_valid && !refuse_d) begin
                  state_q <= `WWLS_ST_DONE;
               end
            end
            `WWLS_ST_DONE: begin
               if (!req_valid) begin
                  state_q <= `WWLS_ST_IDLE;
               end
            end
            default: begin
               state_q <= `WWLS_ST_IDLE;
            end
         endcase
      end
   end
endmodule

/* tb/wwls_steer_sva.sv */
`timescale 1ns/1ps
// port checker for the lane steering block
module wwls_steer_sva #(
   parameter IDX_W = 4
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic req_dual,
   input wire logic req_paired_mode,
   input wire logic req_store,
   input wire logic req_direct,
   input wire logic [1:0] dm_width,
   input wire logic [1:0] pm_width,
   input wire logic [39:0] dm_st_explicit,
   input wire logic [63:0] data_memory_bus_out,
   input wire logic dm_wr_en,
   input wire logic dm_wr_nb_en,
   input wire logic [IDX_W-1:0] dm_wr_idx,
   input wire logic [IDX_W-1:0] dm_wr_nb_idx,
   input wire logic dm_wr_secondary,
   input wire logic [39:0] dm_wr_data,
   input wire logic [39:0] dm_wr_nb_data,
   input wire logic pm_wr_en,
   input wire logic pm_wr_nb_en,
   input wire logic pm_wr_secondary,
   input wire logic req_refused,
   input wire logic req_done
);
   // one clock domain, reset masks all checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   AST_DIRECT_REFUSED: assert property (req_valid && req_dual && req_direct |=>
      req_refused && !dm_wr_en && !pm_wr_en && !req_done) else $error("direct dual taken");
   AST_PAIRED_MIX: assert property (req_valid && req_dual && req_paired_mode &&
      (dm_width[1] != pm_width[1]) |=> req_refused && !dm_wr_en) else $error("mix taken");
   AST_EXT_LOW_ZERO: assert property (req_valid && req_store && dm_width == 2'h2 |=>
      data_memory_bus_out[23:0] == 24'h0) else $error("low bus bits not zero");
   AST_EXT_UPPER: assert property (req_valid && req_store && !req_dual &&
      dm_width == 2'h2 |=> data_memory_bus_out[63:24] == $past(dm_st_explicit))
      else $error("upper lane wrong");
   AST_LONG_ZFILL: assert property (req_valid && !req_store && !req_dual &&
      dm_width == 2'h3 |=> dm_wr_en && dm_wr_nb_en && dm_wr_data[7:0] == 8'h0 &&
      dm_wr_nb_data[7:0] == 8'h0) else $error("long load fill wrong");
   AST_NB_PAIR: assert property (dm_wr_nb_en |->
      dm_wr_nb_idx == (dm_wr_idx ^ IDX_W'(1))) else $error("neighbour index wrong");
   AST_PAIRED_SIDES: assert property (req_valid && req_dual && req_paired_mode &&
      !req_direct && !req_store && dm_width == 2'h2 && pm_width == 2'h2 |=>
      {dm_wr_en, pm_wr_en, dm_wr_secondary, pm_wr_secondary, dm_wr_nb_en, pm_wr_nb_en}
      == 6'h34) else $error("paired sides wrong");
   AST_SINGLE_EXT: assert property (req_valid && !req_dual && !req_store &&
      dm_width == 2'h2 |=> dm_wr_en && !dm_wr_nb_en && !pm_wr_en) else $error("single ext");
endmodule
bind wwls_steer wwls_steer_sva #(.IDX_W(IDX_W)) u_sva (.core_clk(core_clk), .nrst(nrst),
   .req_valid(req_valid), .req_dual(req_dual), .req_paired_mode(req_paired_mode),
   .req_store(req_store), .req_direct(req_direct), .dm_width(dm_width), .pm_width(pm_width),
   .dm_st_explicit(dm_st_explicit), .data_memory_bus_out(data_memory_bus_out),
   .dm_wr_en(dm_wr_en), .dm_wr_nb_en(dm_wr_nb_en), .dm_wr_idx(dm_wr_idx),
   .dm_wr_nb_idx(dm_wr_nb_idx), .dm_wr_secondary(dm_wr_secondary), .dm_wr_data(dm_wr_data),
   .dm_wr_nb_data(dm_wr_nb_data), .pm_wr_en(pm_wr_en), .pm_wr_nb_en(pm_wr_nb_en),
   .pm_wr_secondary(pm_wr_secondary), .req_refused(req_refused), .req_done(req_done));

/* tb/wwls_mem_model.sv */
`timescale 1ns/1ps
// memory blocks: present load words while read, inverted pattern when idle
module wwls_mem_model (
   input wire logic rd,
   input wire logic [63:0] dm_word,
   input wire logic [63:0] pm_word,
   output logic [63:0] dm_rd,
   output logic [63:0] pm_rd
);
   // idle buses never repeat the last word
   assign dm_rd = rd ? dm_word : ~dm_word;
   assign pm_rd = rd ? pm_word : ~pm_word;
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 0, nrst = 0, req_valid = 0, req_dual = 0, pair = 0, st = 0, dir = 0;
   logic dsec = 0, psec = 0, pri = 1;
   logic [1:0] dwid = 0, pwid = 0;
   logic [3:0] didx = 0, pidx = 0;
   logic [39:0] dse = 40'hA5C3F0E1D2, dsn = 40'h123456789A;
   logic [39:0] pse = 40'h3C5A96F00F, psn = 40'h0FEDCBA987;
   logic [63:0] dw = 64'h0123456789ABCDEF, pw = 64'hFEDCBA9876543210, dbi, pbi, dbo, pbo;
   wire dbe, pbe, dwe, dne, pwe, pne, dws, pws, refd, done;
   wire [3:0] dwi, dni, pwi, pni;
   wire [39:0] dwd, dnd, pwd, pnd;
   int bad_count = 0, samples_checked = 0;
   // the block under test
   wwls_steer uut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req_dual(req_dual),
      .req_paired_mode(pair), .req_store(st), .req_direct(dir), .dm_width(dwid),
      .pm_width(pwid), .dm_reg_idx(didx), .pm_reg_idx(pidx), .dm_secondary(dsec),
      .pm_secondary(psec), .dm_has_priority(pri), .dm_st_explicit(dse), .dm_st_neighbour(dsn),
      .pm_st_explicit(pse), .pm_st_neighbour(psn), .data_memory_bus_in(dbi),
      .program_memory_bus_in(pbi), .data_memory_bus_out(dbo), .program_memory_bus_out(pbo),
      .dm_bus_en(dbe), .pm_bus_en(pbe), .dm_wr_en(dwe), .dm_wr_nb_en(dne), .dm_wr_idx(dwi),
      .dm_wr_nb_idx(dni), .dm_wr_secondary(dws), .dm_wr_data(dwd), .dm_wr_nb_data(dnd),
      .pm_wr_en(pwe), .pm_wr_nb_en(pne), .pm_wr_idx(pwi), .pm_wr_nb_idx(pni),
      .pm_wr_secondary(pws), .pm_wr_data(pwd), .pm_wr_nb_data(pnd), .req_refused(refd),
      .req_done(done));
   // memory side model
   wwls_mem_model mem (.rd(req_valid && !st), .dm_word(dw), .pm_word(pw), .dm_rd(dbi),
      .pm_rd(pbi));
   // free-running core clock, 25 ns period
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle request; outputs are settled on return
   task automatic fire(input logic d, input logic [1:0] a, input logic [1:0] b);
      @(negedge core_clk);
      req_dual = d;
      dwid = a;
      pwid = b;
      req_valid = 1;
      @(negedge core_clk);
      req_valid = 0;
   endtask
   // extended words, single and dual, plus a long/short dual and normal words
   task automatic t_ext;
      for (int m = 0; m < 2; m++) begin
         pair = m[0];
         st = 0;
         fire(0, 2'h2, 2'h0);
         chk({dwe, dne, pwe, dwd}, {3'h4, dw[63:24]});
         st = 1;
         fire(0, 2'h2, 2'h0);
         chk(dbo, {dse, 24'h0});
      end
      st = 0;
      fire(1, 2'h2, 2'h2);
      chk({dwe, pwe, dws, pws, dne, pne, pwd}, {6'h34, pw[63:24]});
      pair = 0;
      psec = 1;
      fire(1, 2'h2, 2'h2);
      chk({dwe, pwe, dws, pws}, 4'hD);
      st = 1;
      fire(1, 2'h2, 2'h2);
      chk(pbo, {pse, 24'h0});
      chk({dbe, pbe, dbo[63:24]}, {2'h3, dse});
      st = 0;
      psec = 0;
      fire(1, 2'h3, 2'h0);
      chk({done, refd}, 2'h2);
      chk(pwd, {pw[31:0], 8'h0});
      fire(0, 2'h1, 2'h0);
      chk({dwe, dne, dwd}, {2'h2, dw[31:0], 8'h0});
      st = 1;
      fire(0, 2'h1, 2'h0);
      chk(dbo, {32'h0, dse[39:8]});
      st = 0;
      $display("test ext finished");
   endtask
   // long words, neighbours and conflicts
   task automatic t_long;
      didx = 5;
      fire(0, 2'h3, 2'h0);
      chk({dwe, dne, dni, dwd}, {2'h3, 4'h4, dw[31:0], 8'h0});
      chk(dnd, {dw[63:32], 8'h0});
      st = 1;
      fire(0, 2'h3, 2'h0);
      chk(dbo, {dsn[39:8], dse[39:8]});
      st = 0;
      didx = 2;
      pidx = 6;
      fire(1, 2'h3, 2'h3);
      chk({dwe, dne, pwe, pne, pni}, {4'hF, 4'h7});
      chk({dwi, pwi, pnd}, {4'h2, 4'h6, pw[63:32], 8'h0});
      chk(pwd, {pw[31:0], 8'h0});
      st = 1;
      fire(1, 2'h3, 2'h3);
      chk(pbo, {psn[39:8], pse[39:8]});
      st = 0;
      pidx = 3;
      fire(1, 2'h3, 2'h3);
      chk({dwe, pwe, dbe, pbe}, 4'hA);
      pri = 0;
      fire(1, 2'h3, 2'h3);
      chk({dwe, pwe, dbe, pbe}, 4'h5);
      $display("test long finished");
   endtask
   // refused forms
   task automatic t_refuse;
      dir = 1;
      fire(1, 2'h2, 2'h2);
      chk({refd, done, dwe, pwe}, 4'h8);
      dir = 0;
      pair = 1;
      fire(1, 2'h3, 2'h1);
      chk({refd, done, dwe, pwe}, 4'h8);
      $display("test refuse finished");
   endtask
   // verdict and end of run
   task automatic close_out;
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (6) @(negedge core_clk);
      nrst = 1;
      t_ext();
      t_long();
      t_refuse();
      close_out();
   end
endmodule
